// >>> hdl/loop_through_monitor_ctrl.sv
// Purpose: registers steering the loop-through monitor source and transmitter power
// Assumes: internal register port on the register clock, one access per strobe
// Notes:   primary select, driver enable and pattern enable arrive from their own registers
//
// Operation
// - select 01 routes port 0 stream, 10 routes port 1 stream.
// - power-down bit 0 keeps transmitter on at 0, off at 1; resets 0.
// - source select register resets zero; bits 7-3 and 0 read zero.
// - power register resets zero; bits 7-1 read zero.
// - primary bit 0 names port 0, 1 names port 1.
// - driver enable bit 0 disables, 1 enables the monitor driver.
`timescale 1ns/1ps
`include "monitor_consts.svh"

module loop_through_monitor_ctrl (
    // clock and reset
    input  wire logic                    clock_i,
    input  wire logic                    arst_n_i,
    // register port
    input  wire monitor_pkg::reg_req_t   req_i,
    output logic [7:0]                   rdata_o,
    output logic                         hit_o,
    // unit controls
    input  wire monitor_pkg::unit_ctrl_t unit_i,
    // recovered streams, asynchronous to the register clock
    input  wire logic                    serial_input_port0_i,
    input  wire logic                    serial_input_port1_i,
    // monitor side
    output logic                         loop_through_monitor_output_o,
    output logic                         monitor_driver_active_o,
    output logic                         monitor_transmitter_powerdown_o,
    output logic                         select_mismatch_o
);
    import monitor_pkg::*;

    // ----------------------------------------
    // state
    // ----------------------------------------
    logic [1:0]      monitor_source_select_reg;
    logic [1:0]      monitor_source_select_next;
    logic            monitor_transmitter_powerdown_reg;
    logic            monitor_transmitter_powerdown_next;
    logic [1:0]      port0_sync_reg;
    logic [1:0]      port1_sync_reg;
    logic [7:0]      rdata_reg;
    logic [7:0]      rdata_next;
    logic            hit;
    logic            active;
    monitor_source_t source;

    // ----------------------------------------
    // register writes
    // ----------------------------------------
    always_comb begin
        monitor_source_select_next         = monitor_source_select_reg;
        monitor_transmitter_powerdown_next = monitor_transmitter_powerdown_reg;
        if (req_i.wr) begin
            case (req_i.addr)
                `OFS_SOURCE_SELECT: begin
                    monitor_source_select_next =
                        req_i.wdata[`BIT_SOURCE_SELECT_HI:`BIT_SOURCE_SELECT_LO];
                end
                `OFS_TX_POWER: begin
                    monitor_transmitter_powerdown_next = req_i.wdata[`BIT_TX_POWERDOWN];
                end
                default: begin
                    monitor_source_select_next = monitor_source_select_reg;
                end
            endcase
        end
    end

    // ----------------------------------------
    // read path: reserved bits return zero
    // ----------------------------------------
    always_comb begin
        rdata_next = 8'h00;
        hit        = 1'b0;
        case (req_i.addr)
            `OFS_SOURCE_SELECT: begin
                hit = 1'b1;
                rdata_next[`BIT_SOURCE_SELECT_HI:`BIT_SOURCE_SELECT_LO] = monitor_source_select_reg;
            end
            `OFS_TX_POWER: begin
                hit = 1'b1;
                rdata_next[`BIT_TX_POWERDOWN] = monitor_transmitter_powerdown_reg;
            end
            default: begin
                hit = 1'b0;
            end
        endcase
    end

    always_ff @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            monitor_source_select_reg         <= `RST_SOURCE_SELECT;
            monitor_transmitter_powerdown_reg <= `RST_TX_POWERDOWN;
            rdata_reg                         <= 8'h00;
            port0_sync_reg                    <= 2'h0;
            port1_sync_reg                    <= 2'h0;
        end else begin
            monitor_source_select_reg         <= monitor_source_select_next;
            monitor_transmitter_powerdown_reg <= monitor_transmitter_powerdown_next;
            rdata_reg                         <= rdata_next;
            port0_sync_reg                    <= {port0_sync_reg[0], serial_input_port0_i};
            port1_sync_reg                    <= {port1_sync_reg[0], serial_input_port1_i};
        end
    end

    // ----------------------------------------
    // routing
    // ----------------------------------------
    // driver enable and power state both gate; a powered-down driver never toggles
    assign active = unit_i.monitor_driver_enable && !monitor_transmitter_powerdown_reg;
    assign source = monitor_source_t'(monitor_source_select_reg);

    monitor_stream_mux u_mux (
        .clock_i   (clock_i),
        .arst_n_i  (arst_n_i),
        .source_i  (source),
        .active_i  (active),
        .port0_i   (port0_sync_reg[1]),
        .port1_i   (port1_sync_reg[1]),
        .monitor_o (loop_through_monitor_output_o)
    );

    // flag only; the field alone routes, software keeps the two consistent
    always_comb begin
        case (source)
            SRC_PORT0: select_mismatch_o = unit_i.monitor_port_select_primary;
            SRC_PORT1: select_mismatch_o = !unit_i.monitor_port_select_primary;
            default:   select_mismatch_o = 1'b1;
        endcase
    end

    assign rdata_o                         = rdata_reg;
    assign hit_o                           = hit;
    assign monitor_driver_active_o         = active;
    assign monitor_transmitter_powerdown_o = monitor_transmitter_powerdown_reg;
endmodule

// >>> pkg/monitor_consts.svh
// Purpose: offsets, field positions and reset values of the loop-through monitor controls
// Assumes: 8-bit register bank reached by an internal address/strobe port
// Notes:   definitions only
`ifndef MONITOR_CONSTS_SVH
`define MONITOR_CONSTS_SVH

// ----------------------------------------
// register offsets
// ----------------------------------------
`define OFS_PORT_SELECT_PRIMARY   8'h52
`define OFS_DRIVER_ENABLE         8'h56
`define OFS_SOURCE_SELECT         8'h57
`define OFS_TX_POWER              8'h63
`define OFS_PATTERN_CTRL          8'h64

// ----------------------------------------
// field positions
// ----------------------------------------
`define BIT_PORT_SELECT_PRIMARY   7
`define BIT_DRIVER_ENABLE         3
`define BIT_SOURCE_SELECT_LO      1
`define BIT_SOURCE_SELECT_HI      2
`define BIT_TX_POWERDOWN          0
`define BIT_PATTERN_ENABLE        0

// ----------------------------------------
// reset values and encodings
// ----------------------------------------
`define RST_SOURCE_SELECT         2'h0
`define RST_TX_POWERDOWN          1'h0
`define SRC_SEL_PORT0             2'h1
`define SRC_SEL_PORT1             2'h2

`endif

// >>> pkg/monitor_pkg.sv
// Purpose: types shared by the loop-through monitor control files
// Assumes: nothing beyond the constants header
// Notes:   the three external controls travel together as one struct
package monitor_pkg;

    // ----------------------------------------
    // source choice decoded from the select field
    // ----------------------------------------
    typedef enum logic [1:0] {
        SRC_NONE  = 2'b00,
        SRC_PORT0 = 2'b01,
        SRC_PORT1 = 2'b10
    } monitor_source_t;

    // ----------------------------------------
    // controls held elsewhere in the unit
    // ----------------------------------------
    typedef struct packed {
        logic monitor_port_select_primary;
        logic monitor_driver_enable;
        logic test_image_generator_enable;
    } unit_ctrl_t;

    // ----------------------------------------
    // register port request
    // ----------------------------------------
    typedef struct packed {
        logic       wr;
        logic [7:0] addr;
        logic [7:0] wdata;
    } reg_req_t;

endpackage

// >>> hdl/monitor_stream_mux.sv
// Purpose: gate and route one recovered stream to the loop-through monitor output
// Assumes: stream inputs already lie in the register clock domain
// Notes:   output registered, so it lags the select by one cycle
`timescale 1ns/1ps

module monitor_stream_mux
    import monitor_pkg::*;
(
    // clock and reset
    input  wire logic                    clock_i,
    input  wire logic                    arst_n_i,
    // control
    input  wire monitor_pkg::monitor_source_t source_i,
    input  wire logic                    active_i,
    // streams
    input  wire logic                    port0_i,
    input  wire logic                    port1_i,
    output logic                         monitor_o
);
    logic monitor_reg;
    logic monitor_next;

    // ----------------------------------------
    // selection
    // ----------------------------------------
    always_comb begin
        monitor_next = 1'b0;
        if (active_i) begin
            case (source_i)
                SRC_PORT0: monitor_next = port0_i;
                SRC_PORT1: monitor_next = port1_i;
                default:   monitor_next = 1'b0;
            endcase
        end
    end

    always_ff @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            monitor_reg <= 1'b0;
        end else begin
            monitor_reg <= monitor_next;
        end
    end

    assign monitor_o = monitor_reg;
endmodule

// >>> verification/ltm_ctrl_assertions.sv
// Purpose: port-level checks of the monitor control bank
// Assumes: select field mirrored from writes seen at the register port
// Notes:   stream checks wait for four steady edges, enough for the 3-edge path
`timescale 1ns/1ps
module ltm_ctrl_assertions
    import monitor_pkg::*;
(
    // clock, reset, register port
    input wire logic                    clock_i,
    input wire logic                    arst_n_i,
    input wire monitor_pkg::reg_req_t   req_i,
    input wire logic [7:0]              rdata_o,
    input wire logic                    hit_o,
    // unit controls and streams
    input wire monitor_pkg::unit_ctrl_t unit_i,
    input wire logic                    serial_input_port0_i,
    input wire logic                    serial_input_port1_i,
    // monitor side
    input wire logic                    loop_through_monitor_output_o,
    input wire logic                    monitor_driver_active_o,
    input wire logic                    monitor_transmitter_powerdown_o,
    input wire logic                    select_mismatch_o
);
    logic [1:0] fld_reg;
    logic [1:0] fld_next;
    logic       pri;
    assign pri = unit_i.monitor_port_select_primary;
    always_comb begin
        fld_next = (req_i.wr && req_i.addr == 8'h57) ? req_i.wdata[2:1] : fld_reg;
    end
    always_ff @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) fld_reg <= 2'h0;
        else fld_reg <= fld_next;
    end
    default clocking cb @(posedge clock_i);
    endclocking
    default disable iff (!arst_n_i);
    a_hit_decode: assert property (hit_o == (req_i.addr == 8'h57 || req_i.addr == 8'h63))
        else $error("hit flag wrong");
    a_sel_reserved_zero: assert property ($past(req_i.addr) == 8'h57 |-> rdata_o[7:3] == 5'h0 && !rdata_o[0])
        else $error("select reserved bits not zero");
    a_pwr_reserved_zero: assert property ($past(req_i.addr) == 8'h63 |-> rdata_o[7:1] == 7'h0)
        else $error("power reserved bits not zero");
    a_pwdn_write: assert property (req_i.wr && req_i.addr == 8'h63 |=> monitor_transmitter_powerdown_o == $past(req_i.wdata[0]))
        else $error("powerdown not written");
    a_pwdn_hold: assert property (!(req_i.wr && req_i.addr == 8'h63) |=> $stable(monitor_transmitter_powerdown_o))
        else $error("powerdown changed without write");
    a_driver_gate: assert property (monitor_driver_active_o == (unit_i.monitor_driver_enable && !monitor_transmitter_powerdown_o))
        else $error("driver active wrong");
    a_select_agree: assert property (select_mismatch_o == !(fld_reg == 2'h1 && !pri || fld_reg == 2'h2 && pri))
        else $error("mismatch flag wrong");
    a_route_port0: assert property ((fld_reg == 2'h1 && monitor_driver_active_o) [*4] |-> loop_through_monitor_output_o == $past(serial_input_port0_i, 3))
        else $error("port 0 stream not routed");
    a_route_port1: assert property ((fld_reg == 2'h2 && monitor_driver_active_o) [*4] |-> loop_through_monitor_output_o == $past(serial_input_port1_i, 3))
        else $error("port 1 stream not routed");
    a_silent_off: assert property (!monitor_driver_active_o || fld_reg[0] == fld_reg[1] |=> !loop_through_monitor_output_o)
        else $error("output live while off");
endmodule

// >>> verification/tb_top.sv
// Purpose: directed register and stream tests of the monitor control bank
// Assumes: inputs driven on the falling edge
// Notes:   software ordering rules kept by the sequence itself
`timescale 1ns/1ps
module tb_top
    import monitor_pkg::*;
;
    logic       clk = 1'b0;
    logic       arst_n = 1'b0;
    reg_req_t   req = '0;
    unit_ctrl_t unit = '0;
    logic       s0 = 1'b0;
    logic       s1 = 1'b0;
    logic [7:0] rdata;
    logic       hit, mon, act, pwdn, mism;
    int         errors = 0;
    int         checks_done = 0;
    int         cyc = 0;
    loop_through_monitor_ctrl dut_u (.clock_i(clk), .arst_n_i(arst_n), .req_i(req), .rdata_o(rdata), .hit_o(hit),
        .unit_i(unit), .serial_input_port0_i(s0), .serial_input_port1_i(s1), .loop_through_monitor_output_o(mon),
        .monitor_driver_active_o(act), .monitor_transmitter_powerdown_o(pwdn), .select_mismatch_o(mism));
    initial begin
        forever #10 clk = ~clk;
    end
    task automatic report_and_stop();
        $display("checks %0d errors %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        checks_done++;
        if (got !== exp) begin
            errors++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk);
        req = '{1'b1, a, d};
        @(negedge clk);
        req.wr = 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] exp, input string what);
        @(negedge clk);
        req.addr = a;
        @(negedge clk);
        chk(what, exp, rdata);
    endtask
    // three edges: two sync flops plus the output flop
    task automatic strm(input logic b0, input logic b1, input logic exp);
        @(negedge clk);
        s0 = b0;
        s1 = b1;
        repeat (3) @(negedge clk);
        chk("monitor output", {7'h0, exp}, {7'h0, mon});
    endtask
    always @(posedge clk) begin
        cyc++;
        if (cyc == 1000) begin
            errors++;
            report_and_stop();
        end
    end
    initial begin
        repeat (4) @(negedge clk);
        arst_n = 1'b1;
        rd(8'h57, 8'h00, "select reset");
        chk("hit", 8'h01, {7'h0, hit});
        rd(8'h63, 8'h00, "power reset");
        chk("hit", 8'h01, {7'h0, hit});
        rd(8'h52, 8'h00, "unmapped read");
        chk("hit", 8'h00, {7'h0, hit});
        wr(8'h57, 8'hff);
        rd(8'h57, 8'h06, "select reserved");
        wr(8'h63, 8'hff);
        rd(8'h63, 8'h01, "power reserved");
        chk("powerdown", 8'h01, {7'h0, pwdn});
        unit.test_image_generator_enable = 1'b1;
        wr(8'h52, 8'h00);
        rd(8'h57, 8'h06, "select after unmapped write");
        unit.test_image_generator_enable = 1'b0;
        wr(8'h63, 8'h00);
        chk("powerdown", 8'h00, {7'h0, pwdn});
        unit.monitor_driver_enable = 1'b1;
        for (int k = 0; k < 8; k++) begin
            unit.monitor_port_select_primary = k[2];
            wr(8'h57, {5'h0, k[1:0], 1'b0});
            chk("mismatch", {7'h0, !(k[1:0] == 2'h1 && !k[2] || k[1:0] == 2'h2 && k[2])}, {7'h0, mism});
            strm(1'b1, 1'b0, k[1:0] == 2'h1);
            strm(1'b0, 1'b1, k[1:0] == 2'h2);
        end
        unit.monitor_port_select_primary = 1'b0;
        wr(8'h57, 8'h02);
        strm(1'b1, 1'b0, 1'b1);
        chk("driver active", 8'h01, {7'h0, act});
        wr(8'h63, 8'h01);
        chk("driver active", 8'h00, {7'h0, act});
        strm(1'b1, 1'b0, 1'b0);
        wr(8'h63, 8'h00);
        unit.monitor_driver_enable = 1'b0;
        strm(1'b1, 1'b0, 1'b0);
        report_and_stop();
    end
endmodule
bind loop_through_monitor_ctrl ltm_ctrl_assertions chk_u (.clock_i(clock_i), .arst_n_i(arst_n_i), .req_i(req_i),
    .rdata_o(rdata_o), .hit_o(hit_o), .unit_i(unit_i), .serial_input_port0_i(serial_input_port0_i),
    .serial_input_port1_i(serial_input_port1_i), .loop_through_monitor_output_o(loop_through_monitor_output_o),
    .monitor_driver_active_o(monitor_driver_active_o),
    .monitor_transmitter_powerdown_o(monitor_transmitter_powerdown_o), .select_mismatch_o(select_mismatch_o));
